// >>> logic/mws_pkg.sv
package mws_pkg;
   localparam int          WORD_BITS   = 11;
   localparam int          VALUE_BITS  = 8;
   localparam int          ADDR_BITS   = 3;
   localparam int          NUM_CHAN    = 6;
   localparam int          ADDR_MSB    = 10;
   localparam int          ADDR_LSB    = 8;
   localparam int          VALUE_MSB   = 7;
   localparam int          VALUE_LSB   = 0;
   localparam logic [7:0]  MIDSCALE    = 8'h80;
   localparam logic [10:0] SHIFT_RESET = 11'h000;
   localparam logic [2:0]  CHAN4_LAST  = 3'h3;
   localparam logic [2:0]  CHAN6_LAST  = 3'h5;
   typedef enum logic [1:0]
   {
      MWS_IDLE  = 2'b00,
      MWS_SHIFT = 2'b01
   } mws_state_t;
endpackage

// >>> logic/mws_edge_detect.sv
`timescale 1ns/1ps
module mws_edge_detect
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // Sampled level
   input  wire logic level_in,
   // Edge pulses
   output logic      rise_pulse,
   output logic      fall_pulse
);
   logic prev_reg;
   logic prev_next;

   always_comb
   begin
      prev_next = level_in;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         prev_reg <= 1'b1;
      end
      else
      begin
         prev_reg <= prev_next;
      end
   end

   assign rise_pulse = level_in & ~prev_reg;
   assign fall_pulse = ~level_in & prev_reg;
endmodule

// >>> logic/mws_loader.sv
// Behaviour
// - While select low, shift serial_in on each rising shift clock edge.
// - Eleven-stage shift chain; bit shifted eleven times earlier appears at chain_out.
// - Select low, clock low: chain contents hold, chain output enabled.
// - Select rising edge loads the latch picked by the three address bits.
// - Only the last eleven bits before select rises are kept.
// - Selected latch takes the final eight bits, one channel update.
// - Decoder gated on select rise in an open frame, enabling at most one latch (none for codes above the last channel).
// - Codes 0 to 3 pick channels 1 to 4; 4 and 5 on six-channel only.
// - Select high with preset and power-down idle: no register activity.
// - Preset low sets all latches midscale and clears chain output latch.
// - Preset rising while select high latches 0x80 into every latch.
// - Power-down low releases chain output high; A open, wiper to B.
// - Chain output is open drain, pulling low only.
// - Word is three address bits then eight data bits, MSB first.
// - At power-up every wiper latch is midscale.
// - Power-down keeps all latch values for return to previous settings.
`timescale 1ns/1ps
module mws_loader
   import mws_pkg::*;
#(
   parameter bit SIX_CHANNEL = 1'b1
)
(
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  reset,
   // Serial port
   input  wire logic                  shift_clk,
   input  wire logic                  select_n,
   input  wire logic                  serial_in,
   // Chain output, open drain
   output logic                       chain_out_o,
   output logic                       chain_out_oe_n,
   // Controls
   input  wire logic                  preset_mid_n,
   input  wire logic                  power_down_n,
   // Analog switch controls
   output logic [NUM_CHAN-1:0]        a_open,
   output logic [NUM_CHAN-1:0]        wiper_to_b,
   // Wiper latches
   output logic [NUM_CHAN*8-1:0]      wiper_setting_latch
);
   ////////////////////////////////////////////////////////////////////////
   logic             clk_rise;
   logic             sel_rise;
   logic             sel_fall;
   logic             pre_rise;

   mws_edge_detect u_clk_edge
   (
      .mclk       (mclk),
      .reset      (reset),
      .level_in   (shift_clk),
      .rise_pulse (clk_rise),
      .fall_pulse ()
   );

   mws_edge_detect u_sel_edge
   (
      .mclk       (mclk),
      .reset      (reset),
      .level_in   (select_n),
      .rise_pulse (sel_rise),
      .fall_pulse (sel_fall)
   );

   mws_edge_detect u_pre_edge
   (
      .mclk       (mclk),
      .reset      (reset),
      .level_in   (preset_mid_n),
      .rise_pulse (pre_rise),
      .fall_pulse ()
   );

   ////////////////////////////////////////////////////////////////////////
   mws_state_t       state_reg;
   mws_state_t       state_next;
   logic [10:0]      shift_chain_reg;
   logic [10:0]      shift_chain_next;
   logic             out_latch_reg;
   logic             out_latch_next;

   always_comb
   begin
      state_next       = state_reg;
      shift_chain_next = shift_chain_reg;
      out_latch_next   = out_latch_reg;
      case (state_reg)
         MWS_IDLE:
         begin
            if (sel_fall)
            begin
               state_next = MWS_SHIFT;
            end
         end
         MWS_SHIFT:
         begin
            if (sel_rise)
            begin
               state_next = MWS_IDLE;
            end
         end
         default:
         begin
            state_next = MWS_IDLE;
         end
      endcase
      // older bits fall off the end
      if (!select_n && clk_rise)
      begin
         out_latch_next   = shift_chain_reg[ADDR_MSB];
         shift_chain_next = {shift_chain_reg[ADDR_MSB-1:0], serial_in};
      end
      if (!preset_mid_n)
      begin
         out_latch_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_reg       <= MWS_IDLE;
         shift_chain_reg <= SHIFT_RESET;
         out_latch_reg   <= 1'b0;
      end
      else
      begin
         state_reg       <= state_next;
         shift_chain_reg <= shift_chain_next;
         out_latch_reg   <= out_latch_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [2:0]       chan_addr;
   logic [7:0]       load_value;
   logic [2:0]       chan_last;

   assign chan_addr  = shift_chain_reg[ADDR_MSB:ADDR_LSB];
   assign load_value = shift_chain_reg[VALUE_MSB:VALUE_LSB];
   assign chan_last  = SIX_CHANNEL ? CHAN6_LAST : CHAN4_LAST;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1)
      begin : g_chan
         logic [7:0] latch_reg;
         logic [7:0] latch_next;
         logic       hit;

         // one channel per code
         // Load only once a frame was opened
         assign hit = sel_rise && (state_reg == MWS_SHIFT) && (chan_addr == 3'(ch))
                      && (chan_addr <= chan_last);

         always_comb
         begin
            latch_next = latch_reg;
            if (!preset_mid_n)
            begin
               latch_next = MIDSCALE;
            end
            else if (pre_rise && select_n)
            begin
               latch_next = MIDSCALE;
            end
            else if (hit)
            begin
               latch_next = load_value;
            end
         end

         always_ff @(posedge mclk or posedge reset)
         begin
            if (reset)
            begin
               latch_reg <= MIDSCALE;
            end
            else
            begin
               latch_reg <= latch_next;
            end
         end

         assign wiper_setting_latch[ch*8 +: 8] = latch_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   logic             oe_n_next;
   logic [NUM_CHAN-1:0] sw_next;

   always_comb
   begin
      oe_n_next = ~(power_down_n && !select_n && !out_latch_next);
      sw_next   = power_down_n ? {NUM_CHAN{1'b0}} : {NUM_CHAN{1'b1}};
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         chain_out_oe_n <= 1'b1;
         chain_out_o    <= 1'b0;
         a_open         <= {NUM_CHAN{1'b0}};
         wiper_to_b     <= {NUM_CHAN{1'b0}};
      end
      else
      begin
         chain_out_oe_n <= oe_n_next;
         chain_out_o    <= 1'b0;
         a_open         <= sw_next;
         wiper_to_b     <= sw_next;
      end
   end
endmodule

// >>> testbench/mws_loader_props.sv
`timescale 1ns/1ps
module mws_loader_props
   import mws_pkg::*;
(
   // Clock, reset, inputs
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic                  shift_clk,
   input wire logic                  select_n,
   input wire logic                  preset_mid_n,
   input wire logic                  power_down_n,
   // Outputs
   input wire logic                  chain_out_o,
   input wire logic                  chain_out_oe_n,
   input wire logic [NUM_CHAN-1:0]   a_open,
   input wire logic [NUM_CHAN-1:0]   wiper_to_b,
   input wire logic [NUM_CHAN*8-1:0] wiper_setting_latch
);
   localparam logic [NUM_CHAN*8-1:0] ALL_MID = {NUM_CHAN{MIDSCALE}};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   out_zero_a: assert property (chain_out_o == 1'b0)
      else $error("chain data high");
   pd_release_a: assert property (!power_down_n [*2] |-> chain_out_oe_n)
      else $error("chain not released");
   pd_switch_a: assert property (!power_down_n [*2] |-> &a_open && &wiper_to_b)
      else $error("switches wrong");
   preset_mid_a: assert property (!preset_mid_n [*2] |-> wiper_setting_latch == ALL_MID)
      else $error("preset not midscale");
   sel_idle_a: assert property ((select_n & preset_mid_n) [*4]
      |-> $stable(wiper_setting_latch)) else $error("latch moved");
   hold_chain_a: assert property (
      (!(select_n | shift_clk) & preset_mid_n & power_down_n) [*3] |-> $stable(chain_out_oe_n))
      else $error("chain moved");
   load_time_a: assert property (
      preset_mid_n [*2] ##0 $changed(wiper_setting_latch)
      |-> $past(select_n) && !$past(select_n, 2))
      else $error("load mistimed");
   pwr_mid_a: assert property ($fell(reset) |-> wiper_setting_latch == ALL_MID)
      else $error("reset not midscale");
   cover property ($rose(select_n));
   cover property (!preset_mid_n && !select_n);
   cover property (!power_down_n && !select_n);
endmodule
bind mws_loader mws_loader_props props_u (.*);

// >>> testbench/mws_host.sv
`timescale 1ns/1ps
module mws_host
(
   // Clock and serial port
   input  wire logic mclk,
   output logic      shift_clk = 1'b0,
   output logic      select_n = 1'b1,
   output logic      serial_in = 1'b0
);
   localparam int HALF = 2;
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic send(input logic [21:0] w, input int n, input bit close);
      select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in = w[i];
         tk(HALF);
         shift_clk = 1'b1;
         tk(HALF);
         shift_clk = 1'b0;
      end
      tk(HALF);
      // frame stays open unless closed; idle data flips, no stale bit
      select_n = close;
      serial_in = serial_in ^ close;
      repeat (close ? 4 : 0) tk(1);
   endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import mws_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, preset_mid_n = 1'b1, power_down_n = 1'b1;
   logic shift_clk, select_n, serial_in, chain_out_o, chain_out_oe_n;
   logic [NUM_CHAN-1:0] a_open, wiper_to_b;
   logic [47:0] wiper_setting_latch, exp_latch = {NUM_CHAN{MIDSCALE}};
   int num_errors = 0, checked = 0;
   initial forever #50 mclk = ~mclk;
   mws_host host_u (.*);
   mws_loader dut_u (.*);
   task automatic chk(input logic [47:0] got, want);
      checked++;
      num_errors += int'(got !== want);
      if (got !== want) $display("ERROR %0t got=%h exp=%h", $time, got, want);
   endtask
   task automatic finish_test;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic load_all;
      for (int c = 0; c < 8; c++)
      begin
         host_u.send({11'h0, c[2:0], 8'h21 + c[7:0]}, 11, 1'b1);
         if (c < NUM_CHAN) exp_latch[c*8+:8] = 8'h21 + c[7:0];
         chk(wiper_setting_latch, exp_latch);
      end
   endtask
   task automatic chain_pass;
      for (int b = 0; b < 2; b++)
      begin
         host_u.send({10'h0, b[0], 3'h1, 8'h44 + b[7:0]}, 22, 1'b0);
         // Pull-up makes a released node read high
         chk({47'h0, chain_out_oe_n | chain_out_o}, {47'h0, b[0]});
         host_u.send(22'h0, 0, 1'b1);
         exp_latch[15:8] = 8'h44 + b[7:0];
         chk(wiper_setting_latch, exp_latch);
      end
   endtask
   task automatic preset_win;
      host_u.send(22'h00f, 11, 1'b0);
      preset_mid_n = 1'b0;
      host_u.tk(2);
      // Out latch held a one, so a cleared latch pulls the node low
      chk({47'h0, chain_out_oe_n | chain_out_o}, 48'h0);
      host_u.send(22'h0, 0, 1'b1);
      exp_latch = {NUM_CHAN{MIDSCALE}};
      chk(wiper_setting_latch, exp_latch);
      preset_mid_n = 1'b1;
      host_u.tk(4);
      chk(wiper_setting_latch, exp_latch);
   endtask
   task automatic power_down;
      host_u.send(22'h0, 12, 1'b0);
      power_down_n = 1'b0;
      host_u.tk(2);
      chk({35'h0, chain_out_oe_n, a_open, wiper_to_b}, {35'h0, 13'h1fff});
      host_u.send(22'h0, 0, 1'b1);
      // A frame closed in power-down still loads channel 1 with zero
      exp_latch[7:0] = 8'h00;
      chk(wiper_setting_latch, exp_latch);
      power_down_n = 1'b1;
      host_u.tk(2);
      chk(wiper_setting_latch, exp_latch);
   endtask
   initial #751 reset = 1'b0;
   initial
   begin
      host_u.tk(10);
      chk(wiper_setting_latch, exp_latch);
      load_all();
      chain_pass();
      preset_win();
      power_down();
      finish_test();
   end
endmodule
